/* status_pkg.sv */
// Constants for the standard event status reporting block
package status_pkg;

    // Register indices on the register port
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_ESE = 8'h01;
    localparam logic [7:0] ADDR_ESR = 8'h02;
    localparam logic [7:0] ADDR_SRE = 8'h03;
    localparam logic [7:0] ADDR_STB = 8'h04;
    localparam logic [7:0] ADDR_OUTQ = 8'h05;
    localparam logic [7:0] ADDR_ERRQ = 8'h06;
    localparam logic [7:0] ADDR_ID_MAKER = 8'h07;
    localparam logic [7:0] ADDR_ID_PRODUCT = 8'h08;
    localparam logic [7:0] ADDR_ID_SERIAL = 8'h09;
    localparam logic [7:0] ADDR_ID_VERSION = 8'h0a;
    // Operation set at 0x10, questionable set at 0x18
    localparam logic [7:0] ADDR_SET_BASE = 8'h10;
    localparam logic [2:0] SET_COND = 3'h0;
    localparam logic [2:0] SET_EVENT = 3'h1;
    localparam logic [2:0] SET_ENABLE = 3'h2;
    localparam logic [2:0] SET_PTR = 3'h3;
    localparam logic [2:0] SET_NTR = 3'h4;
    localparam int SET_OPER = 0;
    localparam int SET_QUES = 1;

    // Command register bit positions
    localparam int CMD_CLEAR = 0;
    localparam int CMD_RESET = 1;
    localparam int CMD_OPC = 2;
    localparam int CMD_OPC_QUERY = 3;
    localparam int CMD_WAIT = 4;

    // Status byte bit positions
    localparam int STB_ERRQ = 2;
    localparam int STB_QUES = 3;
    localparam int STB_MAV = 4;
    localparam int STB_ESB = 5;
    localparam int STB_MSS = 6;
    localparam int STB_OPER = 7;

    // Standard event bit for operation complete
    localparam int ESR_OPC = 0;

    // Values after reset
    localparam logic [7:0] ESE_RESET = 8'h00;
    localparam logic [7:0] ESR_RESET = 8'h00;
    localparam logic [7:0] SRE_RESET = 8'h00;
    localparam logic [15:0] SET_ENABLE_RESET = 16'h0000;
    localparam logic [15:0] SET_PTR_RESET = 16'hffff;
    localparam logic [15:0] SET_NTR_RESET = 16'h0000;

    // Answer placed in the output queue for an operation-complete query
    localparam logic [15:0] OPC_ANSWER = 16'h0001;

    // Identity words: arbitrary neutral values
    localparam logic [15:0] ID_MAKER_DEFAULT = 16'h1234;
    localparam logic [15:0] ID_PRODUCT_DEFAULT = 16'h0042;
    localparam logic [15:0] ID_SERIAL_DEFAULT = 16'h0001;
    localparam logic [15:0] ID_VERSION_DEFAULT = 16'h0100;

endpackage

/* std_event_status.sv */
// Standard event status, status byte and operation-complete tracking
`timescale 1ns/100ps

// Function
// - Clear command empties error queue and zeroes all event registers.
// - Clear command keeps enable and transition filter registers unchanged.
// - Clear command cancels armed operation-complete command or query.
// - Reset command cancels operation-complete; pending operations still finish.
// - Standard event enable register is eight bits, bit n weight two-to-n.
// - Status bit 5 is OR of enabled standard event bits.
// - Enable register read returns its eight-bit contents.
// - Reading standard event register returns contents then clears it.
// - Standard event bits stick until read or cleared.
// - No-pending-op flag is zero while any overlapped command is pending.
// - No-pending-op flag is not readable; seen only through completion.
// - Armed operation-complete command sets event bit 0 when flag is one.
// - Armed operation-complete query queues +1 when flag is one.
// - Sequential commands hold later commands; overlapped commands do not.
// - Command completion raises service request only through enabled bit 0, bit 5; query completion through bit 4.
// - Identification gives maker, product, serial and version fields.
// - Request service on status bit rise or enable bit rise.
// - Service-request enable ignores bit 6 on write.
module std_event_status
    import status_pkg::*;
#(
    parameter int ERRQ_DEPTH = 4,
    parameter logic [15:0] ID_MAKER = ID_MAKER_DEFAULT,
    parameter logic [15:0] ID_PRODUCT = ID_PRODUCT_DEFAULT,
    parameter logic [15:0] ID_SERIAL = ID_SERIAL_DEFAULT,
    parameter logic [15:0] ID_VERSION = ID_VERSION_DEFAULT
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    // Instrument events and conditions
    input wire logic [7:0] i_esr_event,
    input wire logic [15:0] i_oper_cond,
    input wire logic [15:0] i_ques_cond,
    input wire logic i_err_valid,
    input wire logic [7:0] i_err_code,
    // Overlapped and sequential command tracking
    input wire logic i_ovl_start,
    input wire logic i_ovl_done,
    input wire logic i_seq_busy,
    // Command hold-off and service request
    output logic o_cmd_hold,
    output logic o_srq,
    output logic [7:0] o_stb
);

    localparam int EQW = $clog2(ERRQ_DEPTH + 1);

    ////////////////////////////////////////////////////////////////////////
    // Decode

    logic wr_cmd;
    logic do_clear;
    logic do_reset;
    logic rd_esr;
    logic rd_outq;
    logic rd_errq;
    logic [1:0] set_sel;
    logic set_hit;

    assign wr_cmd = i_wr && (i_addr == ADDR_CMD);
    assign do_clear = wr_cmd && i_wdata[CMD_CLEAR];
    assign do_reset = wr_cmd && i_wdata[CMD_RESET];
    assign rd_esr = i_rd && (i_addr == ADDR_ESR);
    assign rd_outq = i_rd && (i_addr == ADDR_OUTQ);
    assign rd_errq = i_rd && (i_addr == ADDR_ERRQ);
    // Indices 0 to 4 of each set are mapped, 5 to 7 read as zero
    assign set_hit = (i_addr[7:4] == ADDR_SET_BASE[7:4])
        && (i_addr[2:0] <= SET_NTR);
    assign set_sel[SET_OPER] = set_hit && !i_addr[3];
    assign set_sel[SET_QUES] = set_hit && i_addr[3];

    ////////////////////////////////////////////////////////////////////////
    // Pending overlapped operations

    logic [7:0] pending;
    logic no_pending_op_flag;

    // Counter keeps running through reset commands on purpose
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            pending <= 8'h00;
        end else if (i_ovl_start && !i_ovl_done) begin
            pending <= pending + 8'h01;
        end else if (i_ovl_done && !i_ovl_start && pending != 8'h00) begin
            pending <= pending - 8'h01;
        end
    end

    // Internal only, never placed on the read mux
    assign no_pending_op_flag = (pending == 8'h00);

    ////////////////////////////////////////////////////////////////////////
    // Operation-complete arming

    logic opc_armed;
    logic opcq_armed;
    logic opc_fire;
    logic opcq_fire;
    logic wai_wait;

    assign opc_fire = opc_armed && no_pending_op_flag;
    assign opcq_fire = opcq_armed && no_pending_op_flag;

    // Clear and reset win over a new arm in the same write
    always_ff @(posedge i_mclk) begin
        if (i_rst || do_clear || do_reset) begin
            opc_armed <= 1'b0;
            opcq_armed <= 1'b0;
        end else begin
            if (wr_cmd && i_wdata[CMD_OPC]) begin
                opc_armed <= 1'b1;
            end else if (opc_fire) begin
                opc_armed <= 1'b0;
            end
            if (wr_cmd && i_wdata[CMD_OPC_QUERY]) begin
                opcq_armed <= 1'b1;
            end else if (opcq_fire) begin
                opcq_armed <= 1'b0;
            end
        end
    end

    // Wait-to-continue holds until overlapped work drains
    always_ff @(posedge i_mclk) begin
        if (i_rst || do_reset) begin
            wai_wait <= 1'b0;
        end else if (wr_cmd && i_wdata[CMD_WAIT]) begin
            wai_wait <= 1'b1;
        end else if (no_pending_op_flag) begin
            wai_wait <= 1'b0;
        end
    end

    // Overlapped work alone never holds the parser
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_cmd_hold <= 1'b0;
        end else begin
            o_cmd_hold <= i_seq_busy || wai_wait || opcq_armed;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Standard event register and enable

    logic [7:0] ese;
    logic [7:0] esr;
    logic [7:0] esr_set;

    assign esr_set = i_esr_event | ({7'h00, opc_fire} << ESR_OPC);

    // Sticky bits; a new event wins over a read or clear
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            esr <= ESR_RESET;
        end else if (rd_esr || do_clear) begin
            esr <= esr_set;
        end else begin
            esr <= esr | esr_set;
        end
    end

    // Enable survives clear and reset commands
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            ese <= ESE_RESET;
        end else if (i_wr && i_addr == ADDR_ESE) begin
            ese <= i_wdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Operation and questionable register sets

    logic [15:0] cond_q [2];
    logic [15:0] set_event [2];
    logic [15:0] set_enable [2];
    logic [15:0] set_ptr [2];
    logic [15:0] set_ntr [2];
    logic [15:0] cond_in [2];
    logic [1:0] set_summary;

    assign cond_in[SET_OPER] = i_oper_cond;
    assign cond_in[SET_QUES] = i_ques_cond;

    for (genvar s = 0; s < 2; s++) begin : g_set
        logic [15:0] edge_hit;
        logic wr_here;
        logic rd_event;

        assign edge_hit = (cond_in[s] & ~cond_q[s] & set_ptr[s])
            | (~cond_in[s] & cond_q[s] & set_ntr[s]);
        assign wr_here = i_wr && set_sel[s];
        assign rd_event = i_rd && set_sel[s] && i_addr[2:0] == SET_EVENT;
        assign set_summary[s] = |(set_event[s] & set_enable[s]);

        // Condition history for the transition filters
        always_ff @(posedge i_mclk) begin
            if (i_rst) begin
                cond_q[s] <= 16'h0000;
            end else begin
                cond_q[s] <= cond_in[s];
            end
        end

        // Event latch, cleared by read or clear command
        always_ff @(posedge i_mclk) begin
            if (i_rst) begin
                set_event[s] <= 16'h0000;
            end else if (rd_event || do_clear) begin
                set_event[s] <= edge_hit;
            end else begin
                set_event[s] <= set_event[s] | edge_hit;
            end
        end

        // Enable and filters, untouched by clear
        always_ff @(posedge i_mclk) begin
            if (i_rst) begin
                set_enable[s] <= SET_ENABLE_RESET;
                set_ptr[s] <= SET_PTR_RESET;
                set_ntr[s] <= SET_NTR_RESET;
            end else if (wr_here) begin
                case (i_addr[2:0])
                    SET_ENABLE: set_enable[s] <= i_wdata;
                    SET_PTR: set_ptr[s] <= i_wdata;
                    SET_NTR: set_ntr[s] <= i_wdata;
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output queue, one entry

    logic outq_valid;
    logic [15:0] outq_data;

    // New answer wins over a pop in the same cycle
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            outq_valid <= 1'b0;
            outq_data <= 16'h0000;
        end else if (opcq_fire) begin
            outq_valid <= 1'b1;
            outq_data <= OPC_ANSWER;
        end else if (rd_outq) begin
            outq_valid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Error queue; new errors are dropped when full

    logic [7:0] errq [ERRQ_DEPTH];
    logic [EQW-1:0] errq_count;
    logic errq_push;
    logic errq_pop;

    assign errq_pop = rd_errq && errq_count != '0;
    assign errq_push = i_err_valid && (errq_count != EQW'(ERRQ_DEPTH)
        || errq_pop);

    // Shift queue: head is entry 0
    always_ff @(posedge i_mclk) begin
        if (i_rst || do_clear) begin
            errq_count <= '0;
        end else if (errq_push && !errq_pop) begin
            errq_count <= errq_count + EQW'(1);
        end else if (errq_pop && !errq_push) begin
            errq_count <= errq_count - EQW'(1);
        end
    end

    always_ff @(posedge i_mclk) begin
        for (int i = 0; i < ERRQ_DEPTH; i++) begin
            if (errq_pop && i < ERRQ_DEPTH - 1) begin
                errq[i] <= errq[i + 1];
            end
            if (errq_push && EQW'(i) == errq_count - EQW'(errq_pop)) begin
                errq[i] <= i_err_code;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status byte and service request

    logic [7:0] sre;
    logic [7:0] stb_raw;
    logic [7:0] stb;
    logic [7:0] sre_q;
    logic [7:0] stb_q;

    // Combinational so the summary tracks its sources at once
    always_comb begin
        stb_raw = 8'h00;
        stb_raw[STB_ERRQ] = errq_count != '0;
        stb_raw[STB_QUES] = set_summary[SET_QUES];
        stb_raw[STB_MAV] = outq_valid;
        stb_raw[STB_ESB] = |(esr & ese);
        stb_raw[STB_OPER] = set_summary[SET_OPER];
        stb = stb_raw;
        stb[STB_MSS] = |(stb_raw & sre);
    end

    // Bit 6 is forced off; it never feeds the summary or the request
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            sre <= SRE_RESET;
        end else if (i_wr && i_addr == ADDR_SRE) begin
            sre <= i_wdata[7:0] & ~(8'h01 << STB_MSS);
        end
    end

    // Rising status with enable, or rising enable with status
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            sre_q <= SRE_RESET;
            stb_q <= 8'h00;
            o_srq <= 1'b0;
            o_stb <= 8'h00;
        end else begin
            sre_q <= sre;
            stb_q <= stb;
            o_stb <= stb;
            o_srq <= |((stb & ~stb_q & sre) | (sre & ~sre_q & stb));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the strobe

    logic [15:0] next_rdata;
    logic [1:0] set_idx;

    assign set_idx = i_addr[3] ? 2'd1 : 2'd0;

    always_comb begin
        next_rdata = 16'h0000;
        if (set_hit) begin
            case (i_addr[2:0])
                SET_COND: next_rdata = cond_in[set_idx[0]];
                SET_EVENT: next_rdata = set_event[set_idx[0]];
                SET_ENABLE: next_rdata = set_enable[set_idx[0]];
                SET_PTR: next_rdata = set_ptr[set_idx[0]];
                SET_NTR: next_rdata = set_ntr[set_idx[0]];
                default: next_rdata = 16'h0000;
            endcase
        end else begin
            case (i_addr)
                ADDR_ESE: next_rdata = {8'h00, ese};
                ADDR_ESR: next_rdata = {8'h00, esr};
                ADDR_SRE: next_rdata = {8'h00, sre};
                ADDR_STB: next_rdata = {8'h00, stb};
                ADDR_OUTQ: next_rdata = outq_valid ? outq_data : 16'h0000;
                ADDR_ERRQ: next_rdata = errq_count != '0 ?
                    {8'h00, errq[0]} : 16'h0000;
                ADDR_ID_MAKER: next_rdata = ID_MAKER;
                ADDR_ID_PRODUCT: next_rdata = ID_PRODUCT;
                ADDR_ID_SERIAL: next_rdata = ID_SERIAL;
                ADDR_ID_VERSION: next_rdata = ID_VERSION;
                default: next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_rdata <= 16'h0000;
        end else if (i_rd) begin
            o_rdata <= next_rdata;
        end else begin
            o_rdata <= 16'h0000;
        end
    end

endmodule

/* status_checker_assertions.sv */
// Port-level checks for the status reporting block
`timescale 1ns/100ps
module status_checker
    import status_pkg::*;
#(
    parameter logic [15:0] ID_MAKER = ID_MAKER_DEFAULT
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [15:0] o_rdata,
    // Events and errors
    input wire logic [7:0] i_esr_event,
    input wire logic i_err_valid,
    // Hold-off and status
    input wire logic i_seq_busy,
    input wire logic o_cmd_hold,
    input wire logic o_srq,
    input wire logic [7:0] o_stb
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    ////////////////////////////////////////////////////////////////////////
    // Read port answers
    rdata_idle_a: assert property (
        !$past(i_rd) |-> o_rdata == 16'h0000)
        else $error("read data not idle");
    sre_bit6_a: assert property (
        $past(i_rd && i_addr == ADDR_SRE) |-> !o_rdata[6])
        else $error("service enable bit 6 kept");
    ese_width_a: assert property (
        $past(i_rd && i_addr == ADDR_ESE) |-> o_rdata[15:8] == 8'h00)
        else $error("event enable wider than a byte");
    id_maker_a: assert property (
        $past(i_rd && i_addr == ADDR_ID_MAKER) |-> o_rdata == ID_MAKER)
        else $error("maker field wrong");
    // Second of two back-to-back reads sees a cleared register
    esr_clear_a: assert property (
        (i_rd && i_addr == ADDR_ESR && i_esr_event == 8'h00 && !i_wr)
        ##1 (i_rd && i_addr == ADDR_ESR) |=> o_rdata == 16'h0000)
        else $error("event register not cleared by read");

    ////////////////////////////////////////////////////////////////////////
    // Hold-off, service request and clear
    hold_seq_a: assert property (
        i_seq_busy |=> o_cmd_hold)
        else $error("no hold during sequential command");
    srq_stb_a: assert property (
        o_srq |-> o_stb != 8'h00)
        else $error("service request with empty status");
    clr_errq_a: assert property (
        (i_wr && i_addr == ADDR_CMD && i_wdata[CMD_CLEAR] && !i_err_valid)
        ##1 !i_err_valid |=> !o_stb[STB_ERRQ])
        else $error("error queue kept after clear");
    clr_esb_a: assert property (
        (i_wr && i_addr == ADDR_CMD && i_wdata[CMD_CLEAR]
        && i_esr_event == 8'h00) ##1 i_esr_event == 8'h00
        |=> !o_stb[STB_ESB])
        else $error("event summary kept after clear");
endmodule

/* ovl_agent.sv */
// Overlapped operation engine on the command side of the block
`timescale 1ns/100ps
module ovl_agent (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // Launch request and run length
    input wire logic i_go,
    input wire logic [7:0] i_len,
    // Pulses towards the status block
    output logic o_start,
    output logic o_done
);
    int left;
    // One run at a time; later commands go on meanwhile
    always @(posedge i_mclk) begin
        o_start <= 1'b0;
        o_done <= 1'b0;
        if (i_rst) begin
            left = 0;
        end else if (i_go) begin
            o_start <= 1'b1;
            left = i_len + 1;
        end else if (left > 0) begin
            left = left - 1;
            o_done <= (left == 0);
        end
    end
endmodule

/* test_standard_event_status_reporting.sv */
// Self-checking bench for the status reporting block
`timescale 1ns/100ps
module test_standard_event_status_reporting;
    import status_pkg::*;
    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] i_addr = 8'h00;
    logic [15:0] i_wdata = 16'h0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [7:0] i_esr_event = 8'h00;
    logic i_err_valid = 1'b0;
    logic [7:0] i_err_code = 8'h00;
    logic i_seq_busy = 1'b0;
    logic go = 1'b0;
    logic [7:0] len = 8'h05;
    logic [15:0] oper_cond = 16'h0000;
    logic ovl_start, ovl_done, o_cmd_hold, o_srq;
    logic [15:0] o_rdata;
    logic [7:0] o_stb;
    logic [31:0] seed = 32'h75e70d46;
    int error_cnt = 0, checks_done = 0, cyc = 0, srq_cnt = 0;
    int ese = 0, esr = 0, sre = 0, pend = 0, arm_c = 0, arm_q = 0;
    int errq[$], outq[$];

    always #2 i_mclk = ~i_mclk;

    std_event_status u_dut (.i_mclk(i_mclk), .i_rst(i_rst),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_esr_event(i_esr_event),
        .i_oper_cond(oper_cond), .i_ques_cond(16'h0000),
        .i_err_valid(i_err_valid), .i_err_code(i_err_code),
        .i_ovl_start(ovl_start), .i_ovl_done(ovl_done),
        .i_seq_busy(i_seq_busy), .o_cmd_hold(o_cmd_hold),
        .o_srq(o_srq), .o_stb(o_stb));
    ovl_agent u_agent (.i_mclk(i_mclk), .i_rst(i_rst), .i_go(go),
        .i_len(len), .o_start(ovl_start), .o_done(ovl_done));

    ////////////////////////////////////////////////////////////////////////
    // Reference model of completion tracking
    function automatic void settle();
        if (arm_c != 0) esr |= 1;
        if (arm_q != 0) outq.push_back(1);
        arm_c = 0;
        arm_q = 0;
    endfunction
    always @(posedge i_mclk) begin
        cyc++;
        if (o_srq === 1'b1) srq_cnt++;
        if (ovl_start === 1'b1) pend++;
        if (ovl_done === 1'b1) begin
            pend--;
            if (pend == 0) settle();
        end
        if (cyc == 5000) begin
            error_cnt++;
            conclude();
        end
    end
    function automatic logic [15:0] want(input logic [7:0] a);
        int v = 0;
        case (a)
            ADDR_ESE: v = ese;
            ADDR_SRE: v = sre;
            ADDR_ESR: begin
                v = esr;
                esr = 0;
            end
            ADDR_STB: v = int'((ese & esr) != 0) << STB_ESB;
            ADDR_ERRQ: if (errq.size() > 0) v = errq.pop_front();
            ADDR_OUTQ: if (outq.size() > 0) v = outq.pop_front();
            ADDR_ID_MAKER: v = ID_MAKER_DEFAULT;
            default: v = 0;
        endcase
        return v[15:0];
    endfunction
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Drivers and comparison
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_mclk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
        if (a == ADDR_ESE) ese = d[7:0];
        if (a == ADDR_SRE) sre = d[7:0] & 8'hbf;
        if (a == ADDR_CMD) begin
            if (d[CMD_CLEAR]) begin
                esr = 0;
                errq.delete();
                outq.delete();
            end
            if (d[CMD_CLEAR] || d[CMD_RESET]) {arm_c, arm_q} = 0;
            if (d[CMD_OPC]) arm_c = 1;
            if (d[CMD_OPC_QUERY]) arm_q = 1;
            if (pend == 0) settle();
        end
    endtask
    // Back-to-back reads of one place, n of them
    task automatic rd(input logic [7:0] a, input int n,
            input logic [15:0] m);
        logic [15:0] e;
        @(posedge i_mclk);
        i_addr <= a;
        i_rd <= 1'b1;
        for (int k = 0; k < n; k++) begin
            @(posedge i_mclk);
            if (k == n - 1) i_rd <= 1'b0;
            e = want(a);
            #1;
            chk(o_rdata & m, e & m);
        end
    endtask
    task automatic pulse(input logic [7:0] ev);
        @(posedge i_mclk);
        i_esr_event <= ev;
        @(posedge i_mclk);
        i_esr_event <= 8'h00;
        esr |= ev;
    endtask
    task automatic push(input logic [7:0] c);
        @(posedge i_mclk);
        i_err_code <= c;
        i_err_valid <= 1'b1;
        @(posedge i_mclk);
        i_err_valid <= 1'b0;
        errq.push_back(c);
    endtask
    task automatic launch(input logic [7:0] n);
        @(posedge i_mclk);
        len <= n;
        go <= 1'b1;
        @(posedge i_mclk);
        go <= 1'b0;
    endtask
    task automatic hold_is(input logic h);
        repeat (3) @(posedge i_mclk);
        #1;
        chk({15'h0000, o_cmd_hold}, {15'h0000, h});
    endtask
    task automatic conclude();
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    initial begin
        logic [31:0] r;
        int s;
        repeat (2) @(posedge i_mclk);
        i_rst <= 1'b0;
        rd(ADDR_ESE, 1, 16'hffff);
        rd(ADDR_ESR, 1, 16'hffff);
        wr(8'hfe, 16'h00ff);
        rd(8'hff, 1, 16'hffff);
        rd(ADDR_ID_MAKER, 1, 16'hffff);
        // Random masks and sticky events
        for (int k = 0; k < 6; k++) begin
            r = xs();
            wr(ADDR_ESE, {8'h00, r[7:0]});
            rd(ADDR_ESE, 1, 16'hffff);
            wr(ADDR_SRE, {8'h00, r[15:8]});
            rd(ADDR_SRE, 1, 16'hffff);
            pulse(r[23:16]);
            pulse(r[31:24]);
            repeat (3) @(posedge i_mclk);
            rd(ADDR_STB, 1, 16'h0020);
            rd(ADDR_ESR, 2, 16'hffff);
        end
        // Error queue order, then clear keeps enables
        push(8'h2a);
        push(8'h51);
        rd(ADDR_ERRQ, 1, 16'hffff);
        pulse(8'h81);
        // Rising condition latches an operation event before the clear
        oper_cond <= 16'h0001;
        wr(ADDR_CMD, 16'h0001);
        rd(ADDR_ERRQ, 1, 16'hffff);
        rd({ADDR_SET_BASE[7:3], SET_EVENT}, 1, 16'hffff);
        rd(ADDR_ESR, 1, 16'hffff);
        rd(ADDR_ESE, 1, 16'hffff);
        rd(ADDR_SRE, 1, 16'hffff);
        // Completion request with and without the enable bit
        wr(ADDR_SRE, 16'h0020);
        for (int k = 1; k >= 0; k--) begin
            wr(ADDR_ESE, k[15:0]);
            s = srq_cnt;
            launch(8'h08);
            wr(ADDR_CMD, 16'h0004);
            rd(ADDR_ESR, 1, 16'hffff);
            repeat (16) @(posedge i_mclk);
            chk(16'(srq_cnt - s), k[15:0]);
            rd(ADDR_ESR, 1, 16'hffff);
        end
        // Query answer and hold-off while pending
        launch(8'h0c);
        wr(ADDR_CMD, 16'h0008);
        hold_is(1'b1);
        repeat (16) @(posedge i_mclk);
        rd(ADDR_OUTQ, 2, 16'hffff);
        // Clear, then device reset, cancel both arms mid-run
        for (int k = 0; k < 2; k++) begin
            launch(8'h10);
            wr(ADDR_CMD, 16'h000c);
            wr(ADDR_CMD, 16'h0001 << k);
            // Wait keeps the hold up; the cancelled query must stay silent
            wr(ADDR_CMD, 16'h0010);
            hold_is(1'b1);
            repeat (24) @(posedge i_mclk);
            rd(ADDR_ESR, 1, 16'hffff);
            rd(ADDR_OUTQ, 2, 16'hffff);
        end
        // Sequential command holds later ones
        @(posedge i_mclk);
        i_seq_busy <= 1'b1;
        hold_is(1'b1);
        @(posedge i_mclk);
        i_seq_busy <= 1'b0;
        hold_is(1'b0);
        conclude();
    end
endmodule

bind std_event_status status_checker #(.ID_MAKER(ID_MAKER)) u_chk (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_esr_event(i_esr_event), .i_err_valid(i_err_valid),
    .i_seq_busy(i_seq_busy), .o_cmd_hold(o_cmd_hold), .o_srq(o_srq),
    .o_stb(o_stb));
